// ===== core/adm_consts.vh
// Constants for the converter mode control block
`ifndef ADM_CONSTS_VH
`define ADM_CONSTS_VH
// ==================================================================
// Register map (byte addresses)
`define ADM_MODE_OFF      12'h000
`define ADM_STAT_OFF      12'h004
`define ADM_MODE_RESET    8'h00
// ==================================================================
// Mode register fields
`define ADM_CONV_EN_BIT   7
`define ADM_SCAN_BIT      6
`define ADM_DIV_HI        5
`define ADM_DIV_LO        3
`define ADM_HS5_BIT       2
`define ADM_HS3_BIT       1
`define ADM_BOOST_BIT     0
// ==================================================================
// Status register fields
`define ADM_ST_BUSY_BIT   0
`define ADM_ST_REF_BIT    1
`define ADM_ST_RDY_BIT    2
`define ADM_ST_BAD_BIT    3
// ==================================================================
// Timing
`define ADM_CLK_MHZ       50
`define ADM_SETTLE_HS_US  1
`define ADM_SETTLE_NM_US  14
// Settle counts in core_clk cycles at 50 MHz, sized for the settle counter
`define ADM_SETTLE_HS_CYC 10'd50
`define ADM_SETTLE_NM_CYC 10'd700
// ==================================================================
// Conversion periods in core_clk cycles, 5 V high-speed timing
`define ADM_PER_HS5_0     9'h048
`define ADM_PER_HS5_1     9'h036
`define ADM_PER_HS5_2     9'h024
`define ADM_PER_HS5_3     9'h012
// ==================================================================
// Conversion periods, 3 V high-speed timing
`define ADM_PER_HS3_0     9'h060
`define ADM_PER_HS3_1     9'h048
`define ADM_PER_HS3_2     9'h030
`define ADM_PER_HS3_3     9'h018
`define ADM_PER_HS3_4     9'h0e0
`define ADM_PER_HS3_5     9'h0a8
`define ADM_PER_HS3_6     9'h070
`define ADM_PER_HS3_7     9'h038
// ==================================================================
// Conversion periods, normal timing
`define ADM_PER_NM_0      9'h120
`define ADM_PER_NM_1      9'h0f0
`define ADM_PER_NM_2      9'h0c0
`define ADM_PER_NM_4      9'h090
`define ADM_PER_NM_5      9'h078
`define ADM_PER_NM_6      9'h060
`endif

// ===== core/adm_conv_timer.v
// Conversion period decoder and cycle counter
`timescale 1ns/1ps
`include "adm_consts.vh"
module adm_conv_timer (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       clk_en,
   // Control
   input  wire       run,
   input  wire       restart,
   input  wire       hs5,
   input  wire       hs3,
   input  wire [2:0] div,
   // Status
   output reg        done,
   output reg        bad_cfg
);
   // ==================================================================
   // Period decode
   reg  [8:0] period;
   reg  [8:0] cnt_q;
   always @* begin
      bad_cfg = 1'b0;
      period  = `ADM_PER_NM_0;
      if (hs5 && hs3) begin
         bad_cfg = 1'b1; // R6
      end else if (hs5) begin
         case (div) // R3
            3'h0:    period = `ADM_PER_HS5_0;
            3'h1:    period = `ADM_PER_HS5_1;
            3'h2:    period = `ADM_PER_HS5_2;
            3'h3:    period = `ADM_PER_HS5_3;
            default: bad_cfg = 1'b1;
         endcase
      end else if (hs3) begin
         case (div) // R4
            3'h0:    period = `ADM_PER_HS3_0;
            3'h1:    period = `ADM_PER_HS3_1;
            3'h2:    period = `ADM_PER_HS3_2;
            3'h3:    period = `ADM_PER_HS3_3;
            3'h4:    period = `ADM_PER_HS3_4;
            3'h5:    period = `ADM_PER_HS3_5;
            3'h6:    period = `ADM_PER_HS3_6;
            default: period = `ADM_PER_HS3_7;
         endcase
      end else begin
         case (div) // R5
            3'h0:    period = `ADM_PER_NM_0;
            3'h1:    period = `ADM_PER_NM_1;
            3'h2:    period = `ADM_PER_NM_2;
            3'h4:    period = `ADM_PER_NM_4;
            3'h5:    period = `ADM_PER_NM_5;
            3'h6:    period = `ADM_PER_NM_6;
            default: bad_cfg = 1'b1;
         endcase
      end
   end
   // ==================================================================
   // Counter
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 9'h000;
         done  <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         // Prohibited codes clear the counter rather than run a bogus period
         if (!run || restart || bad_cfg) begin
            cnt_q <= 9'h000; // R11
         end else if (cnt_q == period - 9'h001) begin
            cnt_q <= 9'h000;
            done  <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 9'h001;
         end
      end
   end
endmodule

// ===== core/adm_mode_ctrl.v
// Converter mode register with APB access and boost reference sequencing
// Operation
// R1 - Conversion enable 0 stops conversion, 1 permits it
// R2 - Mode bit 0 selects one channel, 1 scans channels
// R3 - 5V high-speed: codes 0-3 give 72,54,36,18 clocks; others prohibited
// R4 - 3V high-speed: codes give 96,72,48,24,224,168,112,56 clocks
// R5 - Normal: 288,240,192,144,120,96 clocks; codes 3 and 7 prohibited
// R6 - Software never sets both high-speed bits
// R7 - Boost enable 0 stops reference, 1 runs it
// R8 - Reset clears the mode register to zero
// R9 - Register accepts whole byte or single-bit accesses
// R10 - No writes while converting in normal timing
// R11 - High-speed same-value write during conversion restarts it
// R12 - No divider or speed change during conversion
// R13 - Software waits 1 us or 14 us before enabling conversion
// R14 - Pair 00 stopped, 01 standby, 1x converting
// R15 - 00 to 10 turns reference on; clearing with boost 0 turns off
// R16 - 00 to 11 turns reference on; clearing with boost 1 keeps it
// R17 - Software discards first result in software trigger mode
// R18 - Hardware trigger results used only after reference settled
// R19 - No access while running from subclock or internal oscillator
// R20 - Every completed conversion raises the interrupt request
// R21 - Clearing enable mid-conversion drops result without update
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "adm_consts.vh"
module adm_mode_ctrl (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Converter control
   output reg         conv_active,
   output reg         scan_mode,
   output reg         boost_ref_on,
   output reg         conv_start,
   output reg         conversion_irq
);
   // ==================================================================
   // Registers
   reg  [7:0]  mode_q;
   reg  [7:0]  mode_d;
   reg         ref_q;
   reg  [9:0]  settle_q;
   wire        wr;
   wire        wr_mode;
   wire        rd_ok;
   wire        conv_en;
   wire        hs5;
   wire        hs3;
   wire        hs_mode;
   wire        restart;
   wire        done;
   wire        bad_cfg;
   wire        ref_rdy;
   reg         run_q;

   assign conv_en = mode_q[`ADM_CONV_EN_BIT];
   assign hs5     = mode_q[`ADM_HS5_BIT];
   assign hs3     = mode_q[`ADM_HS3_BIT];
   assign hs_mode = hs5 ^ hs3;

   // ==================================================================
   // APB decode
   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign rd_ok   = (paddr == `ADM_MODE_OFF) || (paddr == `ADM_STAT_OFF);
   assign pslverr = psel && penable && !rd_ok;
   assign wr      = psel && penable && pwrite && clk_en;
   assign wr_mode = wr && (paddr == `ADM_MODE_OFF) && pstrb[0]; // R9
   // Same-value write while converting in high-speed timing
   assign restart = wr_mode && conv_en && hs_mode
                    && (pwdata[7:0] == mode_q); // R11

   // Byte lane 0 carries the whole byte; single-bit writes are
   // read-modify-write on the bus side
   always @* begin
      mode_d = mode_q;
      if (wr_mode) begin
         mode_d = pwdata[7:0]; // R9
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= `ADM_MODE_RESET; // R8
      end else if (clk_en) begin
         mode_q <= mode_d;
      end
   end

   // ==================================================================
   // Boost reference sequencing
   // Reference follows boost enable or conversion enable
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_q    <= 1'b0;
         settle_q <= 10'h000;
      end else if (clk_en) begin
         ref_q <= mode_d[`ADM_BOOST_BIT] | mode_d[`ADM_CONV_EN_BIT]; // R7 R14 R15 R16
         if (!ref_q) begin
            settle_q <= 10'h000;
         end else if (!ref_rdy) begin
            settle_q <= settle_q + 10'h001;
         end
      end
   end
   // Settling only reported; software owns the wait before enabling
   assign ref_rdy = hs_mode ? (settle_q >= `ADM_SETTLE_HS_CYC)
                            : (settle_q >= `ADM_SETTLE_NM_CYC); // R13

   // ==================================================================
   // Conversion timer
   adm_conv_timer u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .run      (conv_en),
      .restart  (restart),
      .hs5      (hs5),
      .hs3      (hs3),
      .div      (mode_q[`ADM_DIV_HI:`ADM_DIV_LO]),
      .done     (done),
      .bad_cfg  (bad_cfg)
   );

   // ==================================================================
   // Outputs
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_active    <= 1'b0;
         scan_mode      <= 1'b0;
         boost_ref_on   <= 1'b0;
         conv_start     <= 1'b0;
         conversion_irq <= 1'b0;
         run_q          <= 1'b0;
      end else if (clk_en) begin
         run_q          <= conv_en;
         conv_active    <= conv_en; // R1 R14
         scan_mode      <= mode_q[`ADM_SCAN_BIT]; // R2
         boost_ref_on   <= ref_q;
         // Start pulse on enable, after each result, and on restart
         conv_start     <= conv_en && !bad_cfg && (!run_q || done || restart); // R11
         // Done is only produced while enabled, so a cleared enable drops it
         conversion_irq <= done && conv_en; // R20 R21
      end
   end

   // ==================================================================
   // Read mux
   always @* begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         if (paddr == `ADM_MODE_OFF) begin
            prdata = {24'h00_0000, mode_q};
         end else if (paddr == `ADM_STAT_OFF) begin
            prdata[`ADM_ST_BUSY_BIT] = conv_active;
            prdata[`ADM_ST_REF_BIT]  = ref_q;
            prdata[`ADM_ST_RDY_BIT]  = ref_rdy;
            prdata[`ADM_ST_BAD_BIT]  = bad_cfg;
         end
      end
   end
endmodule

// ===== dv/adm_mode_control_bench.sv
// Self-checking bench for the converter mode control block
`timescale 1ns/1ps
module adm_mode_control_bench;
   // ==========
   // Signals
   reg         core_clk, rst_n, psel, penable, pwrite, es, ce;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [3:0]  pstrb;
   wire        pready, pslverr, conv_active, scan_mode, boost_ref_on, conv_start, conversion_irq;
   wire [31:0] prdata;
   integer     err_total = 0, checks = 0, irq_n = 0, n, c, i;
   reg  [7:0]  cfg [0:5];
   integer     per [0:5];
   adm_mode_ctrl adm_mode_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .conv_active(conv_active), .scan_mode(scan_mode), .boost_ref_on(boost_ref_on),
      .conv_start(conv_start), .conversion_irq(conversion_irq));
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (conversion_irq === 1'b1) irq_n <= irq_n + 1;
   // ==========
   // Tasks
   task complete_run;
      begin
         if (err_total == 0 && checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task cmp(input string what, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // One APB transfer; the setup follows an idle edge
   task apb(input w, input [11:0] a, input [7:0] d, input [3:0] s);
      begin
         @(posedge core_clk);
         psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; pstrb <= s;
         @(posedge core_clk);
         penable <= 1;
         n = 0;
         do begin @(posedge core_clk); n = n + 1; end while (pready !== 1'b1 && n < 20);
         rd = prdata;
         es = pslverr;
         psel <= 0;
         penable <= 0;
         if (n >= 20) begin err_total = err_total + 1; complete_run; end
      end
   endtask
   task wait_sig(input irq);
      begin
         c = 0;
         do begin @(posedge core_clk); c = c + 1; end
         while ((irq ? conversion_irq : conv_start) !== 1'b1 && c < 600);
         if (c >= 600) begin err_total = err_total + 1; complete_run; end
      end
   endtask
   task do_reset;
      begin
         rst_n <= 0;
         repeat (16) @(posedge core_clk);
         rst_n <= 1;
      end
   endtask
   // ==========
   // Sequence
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf; rst_n = 0;
      ce = 1;
      cfg[0] = 8'h80; cfg[1] = 8'hb0; cfg[2] = 8'ha2; cfg[3] = 8'hba; cfg[4] = 8'h84;
      cfg[5] = 8'h9c; per[0] = 288; per[1] = 96; per[2] = 224; per[3] = 56; per[4] = 72;
      per[5] = 18;
      do_reset;
      apb(0, 12'h000, 0, 4'hf); cmp("mode reset", 0, rd);
      apb(1, 12'h000, 8'h41, 4'hf); apb(0, 12'h000, 0, 4'hf); cmp("mode rw", 8'h41, rd);
      cmp("scan", 1, scan_mode); cmp("ref", 1, boost_ref_on); cmp("act", 0, conv_active);
      apb(1, 12'h000, 8'hff, 4'h0); apb(0, 12'h000, 0, 4'hf); cmp("no strobe", 8'h41, rd);
      apb(0, 12'h010, 0, 4'hf); cmp("unmapped err", 1, es); cmp("unmapped data", 0, rd);
      // Clock enable low: the write is not taken and all state holds
      ce <= 0; apb(1, 12'h000, 8'h00, 4'hf); ce <= 1;
      apb(0, 12'h000, 0, 4'hf); cmp("frozen mode", 8'h41, rd);
      cmp("frozen scan", 1, scan_mode);
      for (i = 0; i < 6; i = i + 1) begin
         do_reset;
         apb(1, 12'h000, 8'h01, 4'hf);
         apb(0, 12'h004, 0, 4'hf); cmp("ref settling", 32'h2, rd);
         repeat (700) @(posedge core_clk);
         apb(0, 12'h004, 0, 4'hf); cmp("ref settled", 32'h6, rd);
         apb(1, 12'h000, cfg[i] | 8'h01, 4'hf);
         wait_sig(0);
         wait_sig(1);
         cmp("period", 1, c >= per[i] - 1 && c <= per[i] + 1);
      end
      // Same-value write in high-speed timing restarts the count
      // Fresh reset so that divider and speed bits never change mid-conversion
      do_reset;
      apb(1, 12'h000, 8'hba, 4'hf);
      wait_sig(0);
      repeat (20) @(posedge core_clk);
      apb(1, 12'h000, 8'hba, 4'hf);
      wait_sig(1);
      cmp("restart", 1, c >= 50);
      wait_sig(0);
      repeat (10) @(posedge core_clk);
      apb(1, 12'h000, 8'h3a, 4'hf);
      n = irq_n;
      repeat (100) @(posedge core_clk);
      cmp("abandon", n, irq_n); cmp("ref off", 0, boost_ref_on);
      apb(1, 12'h000, 8'hbb, 4'hf);
      wait_sig(0);
      apb(1, 12'h000, 8'h3b, 4'hf);
      repeat (3) @(posedge core_clk);
      cmp("ref kept", 1, boost_ref_on);
      // Prohibited divider in 5 V timing never converts
      apb(1, 12'h000, 8'ha4, 4'hf);
      n = irq_n;
      repeat (300) @(posedge core_clk);
      cmp("prohibited", n, irq_n);
      apb(0, 12'h004, 0, 4'hf); cmp("status bad", 32'hf, rd);
      complete_run;
   end
endmodule

// ===== dv/adm_mode_properties.sv
// Port checker for the converter mode control block
`timescale 1ns/1ps
module adm_mode_props (
   // Clock and reset
   input wire        core_clk,
   input wire        rst_n,
   input wire        clk_en,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   // Converter
   input wire        conv_active,
   input wire        scan_mode,
   input wire        boost_ref_on,
   input wire        conv_start,
   input wire        conversion_irq
);
   // ==========
   // Helpers
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable;
   wire wr  = acc && pwrite && clk_en && pstrb[0] && paddr == 12'h000;
   wire bad = paddr != 12'h000 && paddr != 12'h004;
   // ==========
   // Assertions
   a_ready_high: assert property (pready) else $error("pready low");
   a_unmapped_err: assert property (acc && bad |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (acc && !bad |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("mapped access bad");
   a_enable_follow: assert property (wr |-> ##2 conv_active == $past(pwdata[7], 2))
      else $error("conv_active wrong");
   a_scan_follow: assert property (wr |-> ##2 scan_mode == $past(pwdata[6], 2))
      else $error("scan_mode wrong");
   a_ref_follow: assert property (wr |-> ##2 boost_ref_on ==
      ($past(pwdata[7], 2) | $past(pwdata[0], 2))) else $error("boost_ref_on wrong");
   a_irq_active: assert property (conversion_irq |-> conv_active)
      else $error("irq while stopped");
   a_start_active: assert property (conv_start |-> conv_active)
      else $error("start while stopped");
   a_irq_restart: assert property (conversion_irq && !$past(acc) && !$past(acc, 2) |-> conv_start)
      else $error("no start after irq");
   a_min_period: assert property (conv_start |=> !conversion_irq [*8])
      else $error("conversion too short");
   a_freeze_hold: assert property (!clk_en |=> $stable(conv_active) &&
      $stable(scan_mode) && $stable(boost_ref_on) && $stable(conv_start) &&
      $stable(conversion_irq)) else $error("state moved while clock enable low");
   cover property (conversion_irq);
   cover property (!clk_en);
   cover property (wr && pwdata[7]);
   cover property (acc && bad);
endmodule

bind adm_mode_ctrl adm_mode_props adm_mode_props_inst (.core_clk(core_clk), .rst_n(rst_n),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .conv_active(conv_active), .scan_mode(scan_mode), .boost_ref_on(boost_ref_on),
   .conv_start(conv_start), .conversion_irq(conversion_irq));
